// ==== inc/lgis_regs.vh ====
`ifndef LGIS_REGS_VH
`define LGIS_REGS_VH

// Register byte offsets on the APB window
`define LGIS_GATE1_SEL_OFS 12'h000
`define LGIS_GATE2_SEL_OFS 12'h004
`define LGIS_GATE3_SEL_OFS 12'h008
`define LGIS_SOURCE_OFS 12'h00C
`define LGIS_INVERT_OFS 12'h010
`define LGIS_STATUS_OFS 12'h014

// Widths
`define LGIS_ADDR_W 12
`define LGIS_SEL_W 8
`define LGIS_SRC_W 16
`define LGIS_FIELD_W 3
`define LGIS_NUM_DATA 4
`define LGIS_NUM_GATE 3

// Source register: one 3-bit field per data selection, 4 bits apart
`define LGIS_SRC_FIELD_STRIDE 4
// Source window of data selection k starts at input 4*k
`define LGIS_SRC_BASE_STEP 4

// Status register fields
`define LGIS_STAT_DATA_LSB 0
`define LGIS_STAT_GATE_LSB 4

// Values after reset of the bus answer and the gate outputs
`define LGIS_PRDATA_RST 32'h00000000
`define LGIS_GATE_RST 3'h0

`endif

// ==== hw/lgis_gate.v ====
`default_nettype none
// One gate: OR of the enabled true and inverted data selections.
module lgis_gate (
  input wire [7:0] enables,
  input wire [3:0] dataTrue,
  input wire invert,
  output wire gateOut
);
  wire [3:0] dataInv;
  wire [7:0] routed;
  wire orOut;

  // Inverted copy kept apart from the true one so both may be used
  assign dataInv = ~dataTrue;

  // Odd bit of each pair carries the true form, even bit the inverted
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : gPair
      assign routed[2*k+1] = enables[2*k+1] & dataTrue[k];
      assign routed[2*k] = enables[2*k] & dataInv[k];
    end
  endgenerate

  // Nothing routed leaves the OR low, so the gate shows its invert bit
  assign orOut = |routed;
  assign gateOut = orOut ^ invert;
endmodule // lgis_gate
`default_nettype wire

// ==== hw/lgis_top.v ====
`include "lgis_regs.vh"
`default_nettype none
// Gate input selection stage with its APB register slave.
module lgis_top (
  // Clock and synchronous active-low reset
  input wire clk,
  input wire rst_b,
  // APB register slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Cell input sources and registered gate outputs
  input wire [15:0] cellIn,
  output reg gateOneOut,
  output reg gateTwoOut,
  output reg gateThreeOut
);

  // Selection and configuration storage. These carry no reset on
  // purpose: they power up unknown and must ride through any reset.
  reg [7:0] gate1Sel_q;
  reg [7:0] gate2Sel_q;
  reg [7:0] gate3Sel_q;
  reg [15:0] source_q;
  reg [2:0] gateInvert_q;

  // Bus response state
  reg [31:0] rdata_d;
  reg addrHit;
  wire setupPhase;
  wire accessDone;
  wire writeEn;
  wire laneLow;
  wire laneHigh;

  // Write strobes, one per stored word or byte; each storage process
  // then reads a single strobe (the source process one per byte) and stays trivially small
  wire wrGate1;
  wire wrGate2;
  wire wrGate3;
  wire wrSrcLow;
  wire wrSrcHigh;
  wire wrInvert;

  // Datapath nets
  wire [3:0] dataSel;
  wire [2:0] gateNext;
  wire [23:0] gateEnables;
  wire [19:0] cellInTwice;

  // A request is decoded in its setup cycle and answered one cycle
  // later, so every transfer sees exactly one access cycle.
  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready;
  assign writeEn = accessDone & pwrite & ~pslverr;
  assign laneLow = pstrb[0];
  assign laneHigh = pstrb[1];

  // Address decode and read mux; unmapped words read zero.
  // The full byte address is matched, so a misaligned word is refused
  // with an error rather than aliased onto its neighbour.
  always @* begin
    rdata_d = `LGIS_PRDATA_RST;
    addrHit = 1'b1;
    case (paddr)
      `LGIS_GATE1_SEL_OFS: begin
        rdata_d[7:0] = gate1Sel_q;
      end
      `LGIS_GATE2_SEL_OFS: begin
        rdata_d[7:0] = gate2Sel_q;
      end
      `LGIS_GATE3_SEL_OFS: begin
        rdata_d[7:0] = gate3Sel_q;
      end
      `LGIS_SOURCE_OFS: begin
        rdata_d[15:0] = source_q;
      end
      `LGIS_INVERT_OFS: begin
        rdata_d[2:0] = gateInvert_q;
      end
      `LGIS_STATUS_OFS: begin
        // Live data selections and the registered gate outputs
        rdata_d[`LGIS_STAT_DATA_LSB+3:`LGIS_STAT_DATA_LSB] = dataSel;
        rdata_d[`LGIS_STAT_GATE_LSB+2:`LGIS_STAT_GATE_LSB] =
          {gateThreeOut, gateTwoOut, gateOneOut};
      end
      default: begin
        addrHit = 1'b0;
      end
    endcase
  end

  // Bus answer: ready and error are raised for the access cycle only.
  // Read data is caught in the setup cycle, so a read returns the word
  // as it stood one cycle before the completing edge.
  always @(posedge clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `LGIS_PRDATA_RST;
    end else if (setupPhase) begin
      pready <= 1'b1;
      pslverr <= ~addrHit;
      prdata <= pwrite ? `LGIS_PRDATA_RST : rdata_d;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Write strobes: a write lands only on the completing edge of its
  // access cycle and only in the byte lanes it enables. A refused
  // transfer, or a write to the read-only status word, matches no
  // strobe and is dropped.
  assign wrGate1 = writeEn & laneLow & (paddr == `LGIS_GATE1_SEL_OFS);
  assign wrGate2 = writeEn & laneLow & (paddr == `LGIS_GATE2_SEL_OFS);
  assign wrGate3 = writeEn & laneLow & (paddr == `LGIS_GATE3_SEL_OFS);
  assign wrSrcLow = writeEn & laneLow & (paddr == `LGIS_SOURCE_OFS);
  assign wrSrcHigh = writeEn & laneHigh & (paddr == `LGIS_SOURCE_OFS);
  assign wrInvert = writeEn & laneLow & (paddr == `LGIS_INVERT_OFS);

  // Gate 1 selection. No reset branch: the bits power up unknown and
  // a warm reset must leave what software wrote in place. Each word
  // has its own process so none picks up a reset branch by accident.
  always @(posedge clk) begin
    if (wrGate1) begin
      gate1Sel_q <= pwdata[7:0];
    end
  end

  // Gate 2 selection, same layout as gate 1
  always @(posedge clk) begin
    if (wrGate2) begin
      gate2Sel_q <= pwdata[7:0];
    end
  end

  // Gate 3 selection, same layout as gate 1
  always @(posedge clk) begin
    if (wrGate3) begin
      gate3Sel_q <= pwdata[7:0];
    end
  end

  // Source fields. Bits 3, 7, 11 and 15 are stored as zero so that a
  // read never returns a stray pad bit.
  always @(posedge clk) begin
    if (wrSrcLow) begin
      source_q[7:0] <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
    end
    if (wrSrcHigh) begin
      source_q[15:8] <= {1'b0, pwdata[14:12], 1'b0, pwdata[10:8]};
    end
  end

  // Per-gate invert bits, also kept through a warm reset
  always @(posedge clk) begin
    if (wrInvert) begin
      gateInvert_q <= pwdata[2:0];
    end
  end

  // Inputs 0 to 3 repeated above input 15 let the data 4 window wrap
  // without a modulo in each multiplexer.
  assign cellInTwice = {cellIn[3:0], cellIn};

  // Input multiplexers: data k picks one of inputs 4k .. 4k+7, mod 16.
  // Field of data k sits at bits 4k+2 .. 4k of the source register.
  genvar d;
  generate
    for (d = 0; d < `LGIS_NUM_DATA; d = d + 1) begin : gMux
      // Window base of this selection; at most 12, so five bits hold
      // the sum with a three-bit field and nothing is cut
      localparam [4:0] WIN_BASE = d * `LGIS_SRC_BASE_STEP;
      wire [2:0] field;
      wire [4:0] index;
      assign field = source_q[d*`LGIS_SRC_FIELD_STRIDE +: `LGIS_FIELD_W];
      assign index = WIN_BASE + {2'b00, field};
      assign dataSel[d] = cellInTwice[index];
    end
  endgenerate

  // Per-gate selection registers laid side by side for the gate loop
  assign gateEnables = {gate3Sel_q, gate2Sel_q, gate1Sel_q};

  // Three identical gates, each with its own enables and invert bit.
  // Gate 4 and the cell's logic function sit outside this stage.
  genvar g;
  generate
    for (g = 0; g < `LGIS_NUM_GATE; g = g + 1) begin : gGate
      lgis_gate uGate (
        .enables(gateEnables[g*8 +: 8]),
        .dataTrue(dataSel),
        .invert(gateInvert_q[g]),
        .gateOut(gateNext[g])
      );
    end
  endgenerate

  // Gate outputs are registered so downstream logic sees clean edges;
  // this costs one cycle of latency from an input change. Reset only
  // clears these outputs; the selections behind them are kept, so the
  // gates resume their old function at the first edge after release.
  always @(posedge clk) begin
    if (!rst_b) begin
      gateOneOut <= 1'b0;
      gateTwoOut <= 1'b0;
      gateThreeOut <= 1'b0;
    end else begin
      gateOneOut <= gateNext[0];
      gateTwoOut <= gateNext[1];
      gateThreeOut <= gateNext[2];
    end
  end

endmodule // lgis_top
`default_nettype wire

// ==== tb/lgis_top_properties.sv ====
`default_nettype none
// Watches the register slave from the ports only
module lgis_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns / 1ps;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  AST_SETUP: assert property (psel && !penable |=> pready)
    else $error("late");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("long");
  AST_IDLE: assert property (!psel |=> !pready)
    else $error("idle");
  AST_PHASE: assert property (pready |-> psel && penable)
    else $error("phase");
  AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("stray");
  AST_UNMAP: assert property (psel && !penable && paddr > 12'h017
    |=> pslverr) else $error("quiet");
  AST_MAP: assert property (psel && !penable && paddr < 12'h018
    && paddr[1:0] == 2'h0 |=> !pslverr) else $error("error");
  AST_WIDTH: assert property (pready && !pwrite && paddr < 12'h00C
    |-> prdata[31:8] == 24'h0) else $error("wide");
  COV_ERR: cover property (pslverr);
  COV_WR: cover property (pready && pwrite);
  COV_RD: cover property (pready && !pwrite);
endmodule // lgis_checker
`default_nettype wire

// ==== tb/test_logic_cell_gate_input_select.sv ====
`default_nettype none
module test_logic_cell_gate_input_select;
  timeunit 1ns / 1ps;
  logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0;
  logic penable = 1'h0, pwrite = 1'h0;
  logic pready, pslverr, gateOneOut, gateTwoOut, gateThreeOut;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic [15:0] cellIn = 16'h0;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  lgis_top lgis_top_inst (
    .clk(clk),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cellIn(cellIn),
    .gateOneOut(gateOneOut),
    .gateTwoOut(gateTwoOut),
    .gateThreeOut(gateThreeOut)
  );
  always #5 clk = ~clk;
  // Hang guard, far past the run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  // Held until pready; a read compares its data against d
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    if (!w) chk("rd", d, prdata);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  // Gates are registered, so let the change settle first
  task automatic gchk(logic [15:0] c, logic [2:0] e);
    cellIn <= c;
    repeat (3) @(posedge clk);
    chk("gate", e, {gateThreeOut, gateTwoOut, gateOneOut});
  endtask
  task automatic t_regs();
    for (int g = 0; g < 3; g++) apb(1'h1, 12'(4 * g), 32'hA5 ^ g);
    for (int g = 0; g < 3; g++) apb(1'h0, 12'(4 * g), 32'hA5 ^ g);
    rst_b <= 1'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    apb(1'h0, 12'h008, 32'hA7);
    apb(1'h0, 12'h040, 32'h0);
    $display("regs done");
  endtask
  // One enable at a time, data low then high, source field zero; then both forms of data 1 on gate 1
  task automatic t_mux();
    for (int g = 0; g < 5; g++) apb(1'h1, 12'(4 * g), 32'h0);
    for (int b = 0; b < 24; b++) begin
      apb(1'h1, 12'(b / 8 * 4), 32'h1 << b % 8);
      gchk(16'h0, 3'(!b[0]) << b / 8);
      gchk(16'h1 << b % 8 / 2 * 4, 3'(b[0]) << b / 8);
      apb(1'h1, 12'(b / 8 * 4), 32'h0);
    end
    apb(1'h1, 12'h000, 32'h3);
    gchk(16'hFFFF, 3'h1);
    $display("mux done");
  endtask
  task automatic t_pol();
    apb(1'h1, 12'h000, 32'h2);
    apb(1'h1, 12'h00C, 32'h5);
    apb(1'h1, 12'h010, 32'h6);
    gchk(16'h0020, 3'h7);
    gchk(16'h0001, 3'h6);
    // Data 4 window wraps: field 7 picks input 3
    apb(1'h1, 12'h00C, 32'h7005);
    apb(1'h1, 12'h000, 32'h80);
    gchk(16'h0008, 3'h7);
    gchk(16'hFFF7, 3'h6);
    apb(1'h0, 12'h00C, 32'h7005);
    apb(1'h0, 12'h010, 32'h6);
    apb(1'h0, 12'h014, 32'h67);
    // Upper lane alone leaves the data 1 and 2 fields untouched
    pstrb <= 4'h2;
    apb(1'h1, 12'h00C, 32'h0);
    pstrb <= 4'hF;
    apb(1'h0, 12'h00C, 32'h5);
    $display("pol done");
  endtask
  task automatic summarize();
    $display("%0d checks, %0d bad", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    t_regs();
    t_mux();
    t_pol();
    summarize();
  end
endmodule // test_logic_cell_gate_input_select
bind lgis_top lgis_checker lgis_checker_inst (
  .clk(clk),
  .rst_b(rst_b),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr)
);
`default_nettype wire
